// >>> verification/interval_timer_props.sv
// checker: bus handshake and interrupt pulse relations at the timer ports
// assumes binding to interval_timer, one clock domain, reset rstn
`timescale 1ns/1ps
module interval_timer_props (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        timer_irq,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  irq_pulse_a: assert property (timer_irq |=> !timer_irq)
    else $error("interrupt longer than one cycle");
  wr_answer_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read data late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answering");
  aw_block_a: assert property (wr_taken |=> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while one waits");
  rdata_width_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
endmodule // interval_timer_props
bind interval_timer interval_timer_props chk (.clock, .rstn, .timer_irq, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

// >>> verification/test_interval_timer.sv
// self-checking bench: register access, prescale, sources, gating, idle, sleep
// assumes the timer design and its constants header are compiled alongside
`timescale 1ns/1ps
`include "interval_timer_consts.svh"
module test_interval_timer;
  logic        clock = 1'h0, rstn = 1'h0, idle_mode = 1'h0, sleep_mode = 1'h0, gate_in = 1'h0;
  logic [2:0]  src = 3'h0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, timer_irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          n_mismatch = 0, checks = 0, cyc = 0, irqs = 0, seed = 32'hcceac1a2;
  interval_timer uut (.clock, .rstn, .clock_enable(1'h1), .idle_mode, .sleep_mode,
    .secondary_oscillator(src[0]), .ext_clock_in(src[1]), .low_power_clock(src[2]), .gate_in,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .timer_irq);
  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (timer_irq === 1'h1) irqs <= irqs + 1;
    if (cyc == 90000) begin
      n_mismatch++;
      conclude();
    end
  end
  task conclude;
    if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clock);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    check({30'h0, s_axi_bresp}, {30'h0, r});
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clock);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    check(s_axi_rdata, e);
    check({30'h0, s_axi_rresp},
          {30'h0, (a[1:0] == 2'h0) ? `RESP_OKAY : `RESP_SLVERR});
  endtask
  function automatic int div_of(input logic [1:0] p);
    return p == 2'h3 ? 256 : p == 2'h2 ? 64 : p == 2'h1 ? 8 : 1;
  endfunction
  // counts k prescaled steps from ticks on the gate or on the masked sources
  task run(input logic [15:0] ctl, input logic [2:0] m, input logic live);
    int per, k, n, i0, d;
    d = div_of(ctl[5:4]);
    per = 2 + $unsigned($random(seed)) % 8;
    k = 1 + $unsigned($random(seed)) % (3 * per + 3);
    if (k % (per + 1) == 0) k++;
    n = k * d + $unsigned($random(seed)) % d;
    wr(`OFS_CONTROL, 32'h0, `RESP_OKAY);
    wr(`OFS_PERIOD, 32'(per), `RESP_OKAY);
    wr(`OFS_COUNT, 32'h0, `RESP_OKAY);
    wr(`OFS_CONTROL, {16'h0, ctl}, `RESP_OKAY);
    i0 = irqs;
    repeat (n) begin
      if (ctl[1]) begin
        src <= m;
        @(posedge clock);
        src <= 3'h0;
      end else gate_in <= 1'h1;
      @(posedge clock);
    end
    gate_in <= 1'h0;
    repeat (8) @(posedge clock);
    if (!live) k = 0;
    rd(`OFS_COUNT, 32'(k % (per + 1)));
    check(32'(irqs - i0), 32'(k / (per + 1) + (live && !ctl[1])));
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rstn <= 1'h1;
    rd(`OFS_CONTROL, 32'h0);
    rd(`OFS_PERIOD, {16'h0, `PERIOD_RESET});
    wr(`OFS_CONTROL, 32'hffffffff, `RESP_OKAY);
    rd(`OFS_CONTROL, {16'h0, `CONTROL_MASK});
    rd(`OFS_STATUS, 32'h1);
    rd(4'h2, 32'h0);
    wr(`OFS_STATUS, 32'h1, `RESP_SLVERR);
    for (int p = 0; p < 4; p++) run(16'h8040 | 16'(p << 4), 3'h0, 1'h1);
    run(16'h0040, 3'h0, 1'h0);
    for (int c = 0; c < 8; c++)
      run(16'h8052 | 16'((c % 4) << 8) | 16'((c / 4) << 2), c % 4 == 3 ? 3'h7 : 3'(1 << c % 4),
        c % 4 != 3);
    sleep_mode <= 1'h1;
    run(16'h8116, 3'h2, 1'h1);
    sleep_mode <= 1'h0;
    idle_mode <= 1'h1;
    run(16'ha116, 3'h2, 1'h0);
    run(16'h8116, 3'h2, 1'h1);
    idle_mode <= 1'h0;
    conclude();
  end
endmodule // test_interval_timer

// >>> verilog/interval_timer.sv
// interval timer: 16-bit timer/counter with AXI4-Lite register slave
// assumes external clock sources arrive synchronous to clock as levels
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "interval_timer_consts.svh"
module interval_timer #(
  parameter int WIDTH = 16
) (
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire logic              clock_enable,
  input  wire logic              idle_mode,
  input  wire logic              sleep_mode,
  input  wire logic              secondary_oscillator,
  input  wire logic              ext_clock_in,
  input  wire logic              low_power_clock,
  input  wire logic              gate_in,
  input  wire logic [3:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [3:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   timer_irq
);

  function automatic interval_timer_pkg::control_type unpack_ctl(input logic [15:0] v);
    interval_timer_pkg::control_type c;
    c.timer_run           = v[`BIT_RUN];
    c.stop_in_idle        = v[`BIT_STOP_IDLE];
    c.ext_clock_select    = v[`BIT_ECS_HI:`BIT_ECS_LO];
    c.gate_accum_enable   = v[`BIT_GATE];
    c.prescale_select     = v[`BIT_PS_HI:`BIT_PS_LO];
    c.ext_clock_sync      = v[`BIT_SYNC];
    c.clock_source_select = v[`BIT_CSRC];
    return c;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) r[7:0] = d[7:0];
    if (strb[1]) r[15:8] = d[15:8];
    return r;
  endfunction

  logic [15:0]            control_reg, control_next;
  logic [WIDTH-1:0]       period_reg, period_next;
  logic [WIDTH-1:0]       count_reg, count_next;
  logic [7:0]             prescale_reg, prescale_next;
  logic                   ext_sync1_reg;
  logic                   ext_sync2_reg;
  logic                   ext_prev_reg;
  logic                   ext_sync1_next;
  logic                   ext_sync2_next;
  logic                   ext_prev_next;
  logic                   gate_prev_reg, gate_prev_next;
  logic                   irq_reg, irq_next;
  logic                   aw_held_reg, aw_held_next;
  logic                   w_held_reg, w_held_next;
  logic [3:0]             awaddr_reg, awaddr_next;
  logic [31:0]            wdata_reg, wdata_next;
  logic [3:0]             wstrb_reg, wstrb_next;
  logic                   bvalid_reg, bvalid_next;
  logic [1:0]             bresp_reg, bresp_next;
  logic                   rvalid_reg, rvalid_next;
  logic [1:0]             rresp_reg, rresp_next;
  logic [31:0]            rdata_reg, rdata_next;
  interval_timer_pkg::bus_state_type rstate_reg, rstate_next;

  interval_timer_pkg::control_type ctl;
  logic                   raw_ext;
  logic                   ext_edge;
  logic                   tick;
  logic                   src_pulse;
  logic                   gated;
  logic                   gate_fall;
  logic [7:0]             ps_limit;
  logic                   wr_fire;
  logic                   count_write;
  logic [31:0]            status_word;

  assign ctl = unpack_ctl(control_reg);

  always_comb begin
    case (ctl.ext_clock_select)
      2'h0:    raw_ext = secondary_oscillator;
      2'h1:    raw_ext = ext_clock_in;
      2'h2:    raw_ext = low_power_clock;
      `ECS_RESERVED: raw_ext = 1'b0;
      default: raw_ext = 1'b0;
    endcase
    case (ctl.prescale_select)
      2'h3:    ps_limit = `PS_DIV256;
      2'h2:    ps_limit = `PS_DIV64;
      2'h1:    ps_limit = `PS_DIV8;
      default: ps_limit = `PS_DIV1;
    endcase
  end

  always_comb begin
    ext_sync1_next = raw_ext;
    ext_sync2_next = ext_sync1_reg;
    // asynchronous mode samples the raw source directly, synchronous one via two stages
    ext_prev_next  = ctl.ext_clock_sync ? ext_sync2_reg : raw_ext;
    ext_edge       = ctl.ext_clock_sync ? (ext_sync2_reg & ~ext_prev_reg)
                                        : (raw_ext & ~ext_prev_reg);
    gated          = ctl.gate_accum_enable & ~ctl.clock_source_select;
    src_pulse      = ctl.clock_source_select ? ext_edge : 1'b1;
    if (gated && !gate_in)
      src_pulse = 1'b0;
    // stop in idle only when selected; sleep halts the instruction clock only
    tick = ctl.timer_run & src_pulse
         & ~(idle_mode & ctl.stop_in_idle)
         & ~(sleep_mode & ~ctl.clock_source_select);
    gate_prev_next = gate_in;
    gate_fall      = gated & gate_prev_reg & ~gate_in;
    // prescaler counts ticks; the count advances when it wraps
    prescale_next  = prescale_reg;
    count_next     = count_reg;
    irq_next       = 1'b0;
    if (tick) begin
      if (prescale_reg >= ps_limit) begin
        prescale_next = 8'h00;
        if (count_reg == period_reg) begin
          count_next = '0;
          irq_next   = 1'b1;
        end else begin
          count_next = count_reg + WIDTH'(1);
        end
      end else begin
        prescale_next = prescale_reg + 8'h01;
      end
    end
    if (!ctl.timer_run)
      prescale_next = 8'h00;
    if (gate_fall && ctl.timer_run)
      irq_next = 1'b1;
    if (count_write) begin
      count_next    = merge16(count_reg, wdata_reg, wstrb_reg);
      prescale_next = 8'h00;
    end
  end

  // write fires once address and data are both held and no write response is pending
  assign wr_fire     = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign count_write = wr_fire & (awaddr_reg == `OFS_COUNT);
  // status: bit 0 run, bit 1 gate level
  assign status_word = {30'h0, gate_in, ctl.timer_run};

  // write channels in either order; readies return as soon as the answer is posted
  always_comb begin
    aw_held_next = aw_held_reg;
    w_held_next  = w_held_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    control_next = control_reg;
    period_next  = period_reg;
    if (s_axi_awvalid && !aw_held_reg) begin
      aw_held_next = 1'b1;
      awaddr_next  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_reg) begin
      w_held_next = 1'b1;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = `RESP_OKAY;
      case (awaddr_reg)
        `OFS_CONTROL: control_next = merge16(control_reg, wdata_reg, wstrb_reg)
                                     & `CONTROL_MASK;
        `OFS_PERIOD:  period_next  = merge16(period_reg, wdata_reg, wstrb_reg);
        `OFS_COUNT:   bresp_next   = `RESP_OKAY;
        default:      bresp_next   = `RESP_SLVERR;
      endcase
    end
    if (bvalid_reg && s_axi_bready)
      bvalid_next = 1'b0;
  end

  // read channel: data answer one cycle after the address is taken
  always_comb begin
    rstate_next = rstate_reg;
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    case (rstate_reg)
      interval_timer_pkg::bus_idle_st: begin
        if (s_axi_arvalid) begin
          rstate_next = interval_timer_pkg::bus_resp_st;
          rvalid_next = 1'b1;
          rresp_next  = `RESP_OKAY;
          case (s_axi_araddr)
            `OFS_CONTROL: rdata_next = {16'h0, control_reg};
            `OFS_PERIOD:  rdata_next = {16'h0, period_reg};
            `OFS_COUNT:   rdata_next = {16'h0, count_reg};
            `OFS_STATUS:  rdata_next = status_word;
            default: begin
              rdata_next = 32'h0;
              rresp_next = `RESP_SLVERR;
            end
          endcase
        end
      end
      interval_timer_pkg::bus_resp_st: begin
        if (s_axi_rready) begin
          rstate_next = interval_timer_pkg::bus_idle_st;
          rvalid_next = 1'b0;
        end
      end
      default: rstate_next = interval_timer_pkg::bus_idle_st;
    endcase
  end

  // all state frozen while clock_enable is low
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      control_reg   <= `CONTROL_RESET;
      period_reg    <= `PERIOD_RESET;
      count_reg     <= '0;
      prescale_reg  <= 8'h00;
      ext_sync1_reg <= 1'b0;
      ext_sync2_reg <= 1'b0;
      ext_prev_reg  <= 1'b0;
      gate_prev_reg <= 1'b0;
      irq_reg       <= 1'b0;
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      awaddr_reg    <= 4'h0;
      wdata_reg     <= 32'h0;
      wstrb_reg     <= 4'h0;
      bvalid_reg    <= 1'b0;
      bresp_reg     <= `RESP_OKAY;
      rvalid_reg    <= 1'b0;
      rresp_reg     <= `RESP_OKAY;
      rdata_reg     <= 32'h0;
      rstate_reg    <= interval_timer_pkg::bus_idle_st;
    end else if (clock_enable) begin
      control_reg   <= control_next;
      period_reg    <= period_next;
      count_reg     <= count_next;
      prescale_reg  <= prescale_next;
      ext_sync1_reg <= ext_sync1_next;
      ext_sync2_reg <= ext_sync2_next;
      ext_prev_reg  <= ext_prev_next;
      gate_prev_reg <= gate_prev_next;
      irq_reg       <= irq_next;
      aw_held_reg   <= aw_held_next;
      w_held_reg    <= w_held_next;
      awaddr_reg    <= awaddr_next;
      wdata_reg     <= wdata_next;
      wstrb_reg     <= wstrb_next;
      bvalid_reg    <= bvalid_next;
      bresp_reg     <= bresp_next;
      rvalid_reg    <= rvalid_next;
      rresp_reg     <= rresp_next;
      rdata_reg     <= rdata_next;
      rstate_reg    <= rstate_next;
    end
  end

  assign s_axi_awready = ~aw_held_reg;
  assign s_axi_wready  = ~w_held_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = (rstate_reg == interval_timer_pkg::bus_idle_st);
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;
  assign timer_irq     = irq_reg;

endmodule // interval_timer

// >>> verilog/interval_timer_consts.svh
// constants for the interval timer: register offsets, field positions, resets
// assumes inclusion by bare name from the design file
`ifndef INTERVAL_TIMER_CONSTS_SVH
`define INTERVAL_TIMER_CONSTS_SVH
`define OFS_CONTROL     4'h0
`define OFS_PERIOD      4'h4
`define OFS_COUNT       4'h8
`define OFS_STATUS      4'hc
`define BIT_RUN         15
`define BIT_STOP_IDLE   13
`define BIT_ECS_HI      9
`define BIT_ECS_LO      8
`define BIT_GATE        6
`define BIT_PS_HI       5
`define BIT_PS_LO       4
`define BIT_SYNC        2
`define BIT_CSRC        1
`define CONTROL_MASK    16'ha376
`define CONTROL_RESET   16'h0000
`define PERIOD_RESET    16'hffff
`define ECS_RESERVED    2'h3
`define PS_DIV1         8'h00
`define PS_DIV8         8'h07
`define PS_DIV64        8'h3f
`define PS_DIV256       8'hff
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

// >>> verilog/interval_timer_pkg.sv
// types for the interval timer
// assumes the constants header for field positions
package interval_timer_pkg;
  typedef struct packed {
    logic       timer_run;
    logic       stop_in_idle;
    logic [1:0] ext_clock_select;
    logic       gate_accum_enable;
    logic [1:0] prescale_select;
    logic       ext_clock_sync;
    logic       clock_source_select;
  } control_type;
  typedef enum logic [1:0] {
    bus_idle_st = 2'b00,
    bus_resp_st = 2'b01
  } bus_state_type;
endpackage
